// File: logic/regmon_pkg.sv
package regmon_pkg;
    // register byte offsets
    localparam logic [8:0] OFS_CTRL   = 9'h114;
    localparam logic [8:0] OFS_LIN_LO = 9'h115;
    localparam logic [8:0] OFS_LIN_HI = 9'h116;
    localparam logic [8:0] OFS_BUCK   = 9'h117;
    localparam logic [8:0] OFS_IRQ_ST = 9'h118;
    localparam logic [8:0] OFS_IRQ_CL = 9'h119;
    localparam logic [8:0] OFS_IRQ_EN = 9'h11a;
    localparam logic [8:0] OFS_IDX12  = 9'h11e;
    localparam logic [8:0] OFS_IDX3   = 9'h11f;
    // control field positions
    localparam int HOLD_LSB = 6;
    localparam int MODE_LSB = 4;
    localparam int DEB_BIT  = 3;
    localparam int RES_BIT  = 2;
    localparam int THR_LSB  = 0;
    localparam int IDX2_LSB = 4;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] EN_RST   = 8'h00;
    // writable masks (reserved bits read zero)
    localparam logic [7:0] LIN_HI_MASK = 8'h07;
    localparam logic [7:0] BUCK_MASK   = 8'hfc;
    localparam logic [7:0] IDX12_MASK  = 8'h77;
    localparam logic [7:0] IDX3_MASK   = 8'h07;
    // status bit of the monitor event
    localparam int EVT_BIT = 0;
    // regulators: linear 0..10, bucks 11..16
    localparam int NREG = 17;
    localparam int NCH  = 3;
    // shift for the base deviation window (one quarter)
    localparam int THR_BASE_SHIFT = 2;
    // modes
    typedef enum logic [1:0] {
        MODE_LOCKOUT = 2'b00,
        MODE_NORMAL  = 2'b01,
        MODE_BURST   = 2'b10,
        MODE_RSVD    = 2'b11
    } mode_e;
    // one finished measurement from a converter channel
    typedef struct packed {
        logic       done;
        logic [7:0] value;
        logic [7:0] target;
    } meas_s;
    // register port bundle
    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } regreq_s;
endpackage

// File: logic/regulator_voltage_monitor.sv
// Overview of operation
// - holdoff compare 0/1/2/4 measurements after enable
// - mode 00: fault raises event, irq, shutdown
// - mode 01: event on every finished measurement
// - mode 10: event after channel three slot
// - debounce bit requires repeated out-of-range
// - reset output on fault when enabled, unmasked
// - window 25, 12.5, 6.25, 3.125 percent
// - 0x115 bit n watches linear n+1
// - 0x116 bits 0..2 watch linear 9..11
// - 0x117 bits 2..7 watch the six bucks
// - channel one index codes report last regulator
// - channel two index codes report last regulator
// - channel three index codes report last regulator
`timescale 1ns/1ps
module regulator_voltage_monitor
    import regmon_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,
    // register port
    input  wire regreq_s           reg_req,
    output logic [7:0]             reg_rdata,
    // regulator state and shutdown
    input  wire logic [NREG-1:0]   reg_on,
    output logic [NREG-1:0]        shutdown_req,
    // converter channels
    output logic [NCH-1:0]         meas_req,
    output logic [NCH-1:0][2:0]    meas_sel,
    input  wire meas_s [NCH-1:0]   meas_in,
    // system outputs
    output logic                   interrupt_out_n,
    output logic                   reset_out_n
);

    // map channel and index code to regulator number (17 = none)
    // reserved codes land on the spare eligibility bit, which stays clear
    function automatic logic [4:0] code_reg(input int ch, input logic [2:0] code);
        logic [4:0] r;
        r = 5'd17;
        case (ch)
            0: case (code)
                3'h1: r = 5'd11;
                3'h2: r = 5'd12;
                3'h3: r = 5'd13;
                3'h4: r = 5'd2;
                3'h5: r = 5'd3;
                3'h6: r = 5'd10;
                default: r = 5'd17;
            endcase
            1: case (code)
                3'h1: r = 5'd14;
                3'h2: r = 5'd15;
                3'h3: r = 5'd16;
                3'h4: r = 5'd0;
                3'h5: r = 5'd1;
                3'h6: r = 5'd4;
                default: r = 5'd17;
            endcase
            default: case (code)
                3'h1: r = 5'd5;
                3'h2: r = 5'd6;
                3'h3: r = 5'd7;
                3'h4: r = 5'd8;
                3'h5: r = 5'd9;
                default: r = 5'd17;
            endcase
        endcase
        return r;
    endfunction

    // next eligible code after cur, wrapping; 0 if none
    // search starts past cur so regulators on one channel take turns
    // seven steps visit every code, cur itself included
    function automatic logic [2:0] next_code(input int ch, input logic [2:0] cur,
                                             input logic [NREG:0] elig);
        logic [2:0] c;
        logic [2:0] n;
        n = 3'h0;
        c = cur;
        for (int i = 0; i < 7; i++) begin
            c = (c == 3'h6) ? 3'h1 : 3'(c + 3'h1);
            if (n == 3'h0 && elig[code_reg(ch, c)]) begin
                n = c;
            end
        end
        return n;
    endfunction

    // software registers
    // reserved bits are masked on write, so they read back as zero
    logic [7:0]  ctrl_q;                  // delay, mode, debounce, reset, window
    logic [7:0]  lin_lo_q;                // linear one..eight watch
    logic [7:0]  lin_hi_q;                // linear nine..eleven watch
    logic [7:0]  buck_q;                  // buck watch
    logic [7:0]  irq_st_q;                // sticky status
    logic [7:0]  irq_en_q;                // status enable (event mask)
    logic [2:0]  idx_q [NCH];             // last measured code per channel
    logic [2:0]  cur_q [NCH];             // code being measured
    logic [NREG-1:0]      reg_on_q;       // for enable edges
    logic [NREG-1:0][2:0] hold_q;         // measurements left before compare
    logic [NREG-1:0]      bad_q;          // previous result out of range
    logic [NREG-1:0]      shut_q;         // shutdown pulses
    logic        rst_q;                   // reset output request
    logic [7:0]  rdata_q;                 // read data

    // decoded fields
    mode_e       mode;
    logic [1:0]  hold_sel;
    logic [1:0]  thr_sel;
    logic        deb_on;
    logic        res_on;
    logic [NREG-1:0] watch;
    logic [NREG:0]   elig;
    logic        wr_clr;

    assign mode     = mode_e'(ctrl_q[MODE_LSB +: 2]);
    assign hold_sel = ctrl_q[HOLD_LSB +: 2];
    assign thr_sel  = ctrl_q[THR_LSB +: 2];
    assign deb_on   = ctrl_q[DEB_BIT];
    assign res_on   = ctrl_q[RES_BIT];
    // clear strobe for the sticky status, decoded once
    assign wr_clr   = reg_req.wr && reg_req.addr == OFS_IRQ_CL;

    // watch enables gathered by regulator number
    assign watch = {buck_q[7:2],
                    lin_hi_q[2:0],
                    lin_lo_q};
    // regulators that may be measured; bit 17 is "none"
    assign elig  = {1'b0, watch & reg_on};

    // holdoff count loaded on a regulator turning on
    // the top code waits four measurements, not three
    function automatic logic [2:0] hold_load(input logic [1:0] sel);
        case (sel)
            2'b00:   return 3'd0;
            2'b01:   return 3'd1;
            2'b10:   return 3'd2;
            default: return 3'd4;
        endcase
    endfunction

    // out of range: |value - target| above target >> (2 + window)
    // nine-bit difference keeps the borrow out of the compare
    // a deviation equal to the limit still counts as in range
    function automatic logic out_of_range(input meas_s m, input logic [1:0] sel);
        logic [8:0] diff;
        logic [7:0] lim;
        diff = (m.value >= m.target) ? {1'b0, m.value} - {1'b0, m.target}
                                     : {1'b0, m.target} - {1'b0, m.value};
        lim  = m.target >> (THR_BASE_SHIFT + int'(sel));
        return diff > {1'b0, lim};
    endfunction

    // per-channel result decoding
    // a done without a request is dropped here
    // limitation: debounce looks back one compared result only
    logic [NCH-1:0]      fin;          // accepted measurement
    logic [NCH-1:0][4:0] fin_reg;      // its regulator
    logic [NCH-1:0]      fin_fault;    // confirmed fault
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            fin[c]       = meas_req[c] && meas_in[c].done;
            fin_reg[c]   = code_reg(c, cur_q[c]);
            fin_fault[c] = 1'b0;
            if (fin[c] && fin_reg[c] < 5'(NREG)) begin
                // compare only once holdoff expired
                if (hold_q[fin_reg[c]] == 3'd0 &&
                    out_of_range(meas_in[c], thr_sel)) begin
                    // debounce wants two in a row
                    fin_fault[c] = !deb_on || bad_q[fin_reg[c]];
                end
            end
        end
    end

    // event sources by mode
    // the reserved mode still runs range checks; it raises no event, but faults still reach the reset output
    logic evt;
    logic any_fault;
    assign any_fault = |fin_fault;
    always_comb begin
        case (mode)
            MODE_LOCKOUT: evt = any_fault;
            MODE_NORMAL:  evt = |fin;
            MODE_BURST:   evt = fin[2];
            default:      evt = 1'b0;  // reserved code raises no event
        endcase
    end

    // control and enable registers
    // index fields are written in the sequencer block, not here
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q   <= CTRL_RST;
            lin_lo_q <= EN_RST;
            lin_hi_q <= EN_RST;
            buck_q   <= EN_RST;
            irq_en_q <= EN_RST;
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                OFS_CTRL:   ctrl_q   <= reg_req.wdata;
                OFS_LIN_LO: lin_lo_q <= reg_req.wdata;
                OFS_LIN_HI: lin_hi_q <= reg_req.wdata & LIN_HI_MASK;
                OFS_BUCK:   buck_q   <= reg_req.wdata & BUCK_MASK;
                OFS_IRQ_EN: irq_en_q <= reg_req.wdata;
                default: ;
            endcase
        end
    end

    // sticky status; a new event wins over a clear
    // so software clearing in the event's cycle never loses it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_st_q <= 8'h00;
        end else begin
            irq_st_q <= (irq_st_q & ~(wr_clr ? reg_req.wdata : 8'h00))
                        | (8'(evt) << EVT_BIT);
        end
    end

    // channel sequencers and index fields
    // a regulator that drops out is left at once, not waited on
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int c = 0; c < NCH; c++) begin
                idx_q[c] <= 3'h0;
                cur_q[c] <= 3'h0;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                // idle or current one dropped out: find another
                if (!elig[code_reg(c, cur_q[c])] || fin[c]) begin
                    cur_q[c] <= next_code(c, cur_q[c], elig);
                end
                if (fin[c]) begin
                    idx_q[c] <= cur_q[c];
                end
            end
            // software writes to the index fields, measurement wins
            if (reg_req.wr && reg_req.addr == OFS_IDX12) begin
                if (!fin[0]) idx_q[0] <= reg_req.wdata[2:0];
                if (!fin[1]) idx_q[1] <= reg_req.wdata[IDX2_LSB +: 3];
            end
            if (reg_req.wr && reg_req.addr == OFS_IDX3 && !fin[2]) begin
                idx_q[2] <= reg_req.wdata[2:0];
            end
        end
    end

    // measurement requests follow the current code
    // a level, falling as soon as the regulator turns off
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            meas_req[c] = cur_q[c] != 3'h0 && elig[code_reg(c, cur_q[c])];
            meas_sel[c] = cur_q[c];
        end
    end

    // holdoff counters and debounce history per regulator
    // turning off and on again restarts holdoff and history
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_on_q <= '0;
            hold_q   <= '0;
            bad_q    <= '0;
        end else begin
            reg_on_q <= reg_on;
            for (int r = 0; r < NREG; r++) begin
                if (reg_on[r] && !reg_on_q[r]) begin
                    hold_q[r] <= hold_load(hold_sel);
                    bad_q[r]  <= 1'b0;
                end
            end
            for (int c = 0; c < NCH; c++) begin
                if (fin[c] && fin_reg[c] < 5'(NREG)) begin
                    if (hold_q[fin_reg[c]] != 3'd0) begin
                        hold_q[fin_reg[c]] <= 3'(hold_q[fin_reg[c]] - 3'd1);
                    end else begin
                        bad_q[fin_reg[c]] <= out_of_range(meas_in[c], thr_sel);
                    end
                end
            end
        end
    end

    // shutdown pulses in lockout mode only
    // one pulse per fault; the regulator itself latches the off state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shut_q <= '0;
        end else begin
            shut_q <= '0;
            if (mode == MODE_LOCKOUT) begin
                for (int c = 0; c < NCH; c++) begin
                    if (fin_fault[c]) shut_q[fin_reg[c]] <= 1'b1;
                end
            end
        end
    end
    assign shutdown_req = shut_q;

    // reset output: needs both the enable and an unmasked fault
    // a masked fault thus never resets the system
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_q <= 1'b0;
        end else begin
            rst_q <= any_fault && res_on && irq_en_q[EVT_BIT];
        end
    end
    assign reset_out_n = !rst_q;

    // interrupt line, level while an enabled bit is set
    assign interrupt_out_n = !(|(irq_st_q & irq_en_q));

    // read data, one cycle after the strobe; unmapped reads zero
    // zero outside the answer cycle so a stale byte never looks valid
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                OFS_CTRL:   rdata_q <= ctrl_q;
                OFS_LIN_LO: rdata_q <= lin_lo_q;
                OFS_LIN_HI: rdata_q <= lin_hi_q;
                OFS_BUCK:   rdata_q <= buck_q;
                OFS_IRQ_ST: rdata_q <= irq_st_q;
                OFS_IRQ_EN: rdata_q <= irq_en_q;
                OFS_IDX12:  rdata_q <= {1'b0, idx_q[1], 1'b0, idx_q[0]};
                OFS_IDX3:   rdata_q <= {5'h00, idx_q[2]};
                default:    rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

endmodule

// File: verification/regmon_sva.sv
`timescale 1ns/1ps
module regmon_sva
    import regmon_pkg::*;
(
    // clock and reset
    input wire logic                clk,
    input wire logic                nrst,
    // register port
    input wire regreq_s             reg_req,
    input wire logic [7:0]          reg_rdata,
    // regulators and channels
    input wire logic [NREG-1:0]     reg_on,
    input wire logic [NREG-1:0]     shutdown_req,
    input wire logic [NCH-1:0]      meas_req,
    input wire logic [NCH-1:0][2:0] meas_sel,
    input wire meas_s [NCH-1:0]     meas_in,
    // system outputs
    input wire logic                interrupt_out_n,
    input wire logic                reset_out_n
);
    logic [NCH-1:0] took;  // measurements accepted this cycle
    assign took = meas_req & {meas_in[2].done, meas_in[1].done, meas_in[0].done};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_rdata_idle: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
        else $error("read data outside a read answer");
    a_one_sel_ok: assert property (meas_req[0] |-> meas_sel[0] inside {[3'h1:3'h6]})
        else $error("channel one asks with a bad code");
    a_two_sel_ok: assert property (meas_req[1] |-> meas_sel[1] inside {[3'h1:3'h6]})
        else $error("channel two asks with a bad code");
    a_three_sel_ok: assert property (meas_req[2] |-> meas_sel[2] inside {[3'h1:3'h5]})
        else $error("channel three asks with a bad code");
    a_shut_was_on: assert property ((shutdown_req & ~$past(reg_on)) == '0)
        else $error("shutdown of a regulator that was off");
    a_shut_has_cause: assert property (|shutdown_req |-> $past(|took))
        else $error("shutdown without a measurement");
    a_shut_one_cause: assert property ((shutdown_req & 17'h03c0c) != '0 |-> $past(took[0]))
        else $error("channel one shutdown without its measurement");
    a_reset_has_cause: assert property (!reset_out_n |-> $past(|took))
        else $error("reset output without a measurement");
    a_quiet_start: assert property ($rose(nrst) |-> interrupt_out_n && reset_out_n)
        else $error("outputs active right after reset");
endmodule
bind regulator_voltage_monitor regmon_sva regmon_sva_i (.clk(clk), .nrst(nrst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_on(reg_on), .shutdown_req(shutdown_req),
    .meas_req(meas_req), .meas_sel(meas_sel), .meas_in(meas_in),
    .interrupt_out_n(interrupt_out_n), .reset_out_n(reset_out_n));

// File: verification/converter_model.sv
`timescale 1ns/1ps
module converter_model
    import regmon_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,
    // requests and bench controls
    input  wire logic [NCH-1:0]    meas_req,
    input  wire logic signed [8:0] dev,
    input  wire logic              slow,
    // finished measurements
    output meas_s [NCH-1:0]        meas_in
);
    logic [1:0] pace_q;  // slow pacing, one result in four cycles
    // value toggles when idle so a stale sample never looks valid
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pace_q  <= '0;
            meas_in <= '0;
        end else begin
            pace_q <= pace_q + 2'h1;
            for (int c = 0; c < NCH; c++) begin
                meas_in[c].done   <= meas_req[c] && (!slow || pace_q == 2'h0);
                meas_in[c].target <= 8'h80;
                meas_in[c].value  <= meas_req[c] ? 8'(9'sh080 + dev) : ~meas_in[c].value;
            end
        end
    end
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    import regmon_pkg::*;
    logic                clk = 1'b0;
    logic                nrst;
    regreq_s             reg_req = '0;
    logic [7:0]          reg_rdata;
    logic [NREG-1:0]     reg_on = '0;
    logic [NREG-1:0]     shutdown_req;
    logic [NCH-1:0]      meas_req;
    logic [NCH-1:0][2:0] meas_sel;
    meas_s [NCH-1:0]     meas_in;
    logic                interrupt_out_n;
    logic                reset_out_n;
    logic signed [8:0]   dev = '0;   // measured minus target
    logic                slow = 1'b0; // slow converter pacing
    logic [31:0]         seed = 32'h2c19c3e6;
    logic [7:0]          rv;
    int                  err_count = 0;
    int                  n_compared = 0;
    int                  meas_n = 0;   // channel one measurements since arm
    int                  first_n = -1; // measurements up to first cut
    int                  shut_n = 0;
    int                  rst_cnt = 0;
    localparam logic [8:0] OFS [9] = '{OFS_CTRL, OFS_LIN_LO, OFS_LIN_HI, OFS_BUCK,
        OFS_IDX12, OFS_IDX3, OFS_IRQ_ST, OFS_IRQ_CL, 9'h113};
    localparam logic [7:0] MSK [6] = '{8'hff, 8'hff, LIN_HI_MASK, BUCK_MASK, IDX12_MASK,
        IDX3_MASK};
    // channel and code of each regulator, as {channel, code}
    localparam logic [4:0] SLOT [NREG] = '{5'h0c, 5'h0d, 5'h04, 5'h05, 5'h0e, 5'h11, 5'h12,
        5'h13, 5'h14, 5'h15, 5'h06, 5'h01, 5'h02, 5'h03, 5'h09, 5'h0a, 5'h0b};
    localparam logic [7:0] HOLD_EXP [5] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h02};
    regulator_voltage_monitor regulator_voltage_monitor_i (.clk(clk), .nrst(nrst),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_on(reg_on), .shutdown_req(shutdown_req),
        .meas_req(meas_req), .meas_sel(meas_sel), .meas_in(meas_in),
        .interrupt_out_n(interrupt_out_n), .reset_out_n(reset_out_n));
    converter_model converter_model_i (.clk(clk), .nrst(nrst), .meas_req(meas_req),
        .dev(dev), .slow(slow), .meas_in(meas_in));
    always #2 clk = ~clk;
    // regulators obey shutdown; tally measurements, cuts, reset pulses
    always @(posedge clk) begin
        if (meas_req[0] && meas_in[0].done)
            meas_n <= meas_n + 1;
        if (shutdown_req[2] && first_n < 0)
            first_n <= meas_n;
        if (!reset_out_n)
            rst_cnt <= rst_cnt + 1;
        if (|shutdown_req) begin
            shut_n <= shut_n + 1;
            reg_on <= reg_on & ~shutdown_req;
        end
    end
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        reg_req <= '0;
    endtask
    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        reg_req <= '0;
        #1 d = reg_rdata;
    endtask
    task automatic rchk(input logic [8:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk($sformatf("reg %h", a), exp, v);
    endtask
    // off, clear the event, zero the tallies, then power the given set
    task automatic arm(input logic [NREG-1:0] on);
        reg_on <= '0;
        wait_n(3);
        wr(OFS_IRQ_CL, 8'h01);
        meas_n = 0;
        first_n = -1;
        shut_n = 0;
        rst_cnt = 0;
        reg_on <= on;
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog, far beyond the expected run
    initial begin
        #200000;
        err_count++;
        results();
    end
    initial begin
        nrst = 1'b0;
        wait_n(10);
        nrst <= 1'b1;
        for (int i = 0; i < 9; i++)
            rchk(OFS[i], 8'h00);
        for (int i = 0; i < 6; i++) begin
            rv = rnd();
            wr(OFS[i], rv);
            rchk(OFS[i], rv & MSK[i]);
        end
        wr(OFS_IRQ_ST, 8'hff);
        rchk(OFS_IRQ_ST, 8'h00);
        for (int i = 0; i < 6; i++)
            wr(OFS[i], 8'h00);
        $display("test registers done");
        // one regulator at a time, random in-range deviation
        wr(OFS_IRQ_EN, 8'h01);
        wr(OFS_CTRL, 8'h10);
        for (int r = 0; r < NREG; r++) begin
            dev <= 9'(rnd() & 8'h1f);
            wr(OFS_LIN_LO, 8'(17'h1 << r));
            wr(OFS_LIN_HI, 8'((17'h1 << r) >> 8) & LIN_HI_MASK);
            wr(OFS_BUCK, 8'((17'h1 << r) >> 9) & BUCK_MASK);
            arm(17'h1 << r);
            wait_n(8);
            rd(SLOT[r][4] ? OFS_IDX3 : OFS_IDX12, rv);
            rv = (rv >> (SLOT[r][3] ? IDX2_LSB : 0)) & 8'h07;
            chk("index", 8'(SLOT[r][2:0]), rv);
        end
        rchk(OFS_IRQ_ST, 8'h01);
        chk("irq", 8'h00, 8'(interrupt_out_n));
        $display("test index done");
        // channel one alone, then channel three added
        wr(OFS_LIN_LO, 8'h24);
        dev <= '0;
        for (int m = 0; m < 4; m++) begin
            wr(OFS_CTRL, 8'(m << MODE_LSB));
            arm(17'h4);
            wait_n(12);
            rchk(OFS_IRQ_ST, 8'(m == 1));
            reg_on <= 17'h24;
            wait_n(12);
            rchk(OFS_IRQ_ST, 8'(m == 1 || m == 2));
        end
        $display("test modes done");
        // window edge: exactly at the limit passes, one beyond fails
        wr(OFS_LIN_LO, 8'h04);
        for (int w = 0; w < 4; w++) begin
            for (int k = 0; k < 2; k++) begin
                rv = (8'h80 >> (THR_BASE_SHIFT + w)) + 8'(k);
                dev <= w[0] ? -9'(rv) : 9'(rv);
                wr(OFS_CTRL, 8'(w) | 8'h04);
                arm(17'h4);
                wait_n(12);
                rchk(OFS_IRQ_ST, 8'(k));
                chk("cut", 8'(k), 8'(shut_n > 0));
                chk("reset", 8'(k), 8'(rst_cnt > 0));
                chk("irq", 8'(k == 0), 8'(interrupt_out_n));
            end
        end
        wr(OFS_IRQ_EN, 8'h00);
        wait_n(1);
        chk("irq", 8'h01, 8'(interrupt_out_n));
        arm(17'h4);
        wait_n(12);
        chk("reset", 8'h00, 8'(rst_cnt > 0));
        wr(OFS_IRQ_EN, 8'h01);
        $display("test window done");
        // holdoff codes, then debounce after an in-range history
        for (int h = 0; h < 5; h++) begin
            slow <= h[0];
            wr(OFS_CTRL, h < 4 ? 8'(h << HOLD_LSB) : 8'h08);
            if (h == 4) begin
                dev <= '0;
                arm(17'h4);
                wait_n(6);
            end
            dev <= 9'h030;
            arm(17'h4);
            wait_n(40);
            chk("holdoff", HOLD_EXP[h], 8'(first_n));
        end
        $display("test holdoff done");
        // reset in mid-run: registers back to zero, lines quiet again
        chk("irq", 8'h00, 8'(interrupt_out_n));
        @(posedge clk);
        nrst <= 1'b0;
        wait_n(10);
        nrst <= 1'b1;
        chk("irq", 8'h01, 8'(interrupt_out_n));
        chk("reset", 8'h01, 8'(reset_out_n));
        for (int i = 0; i < 9; i++)
            rchk(OFS[i], 8'h00);
        $display("test reset done");
        results();
    end
endmodule
